// file: rtl/cfg_pkg.sv
// Constants and types for the configuration word decoder
// How it works
// - Select 111/110/101 take external logic clock, high/medium/low power.
// - Select 100 picks internal oscillator, 011 picks external RC.
// - Select 010/001/000 pick crystal in high, standard, low gain.
// - Low-voltage enable 1 permits it; 0 requires high voltage on reset pin.
// - In low-voltage programming the enable bit cannot be programmed to 0.
// - Debugger bit 0 dedicates serial programming pins to the debugger.
// - Brown-out level bit 1 selects low trip, 0 selects high trip.
// - Stack-fault enable 1 lets stack faults reset the device.
// - Multiplier enable bit 1 turns on the four-times PLL.
// - Unimplemented bits read as 1; reserved bit 4 should be programmed 1.
// - Self-write field 11 none, 10 to 1FFh, 01 to 7FFh, 00 all.
// - Program protect 0 blocks external program access; reads return zero.
// - CPU and internal accesses are never affected by code protection.
// - Data protect 0 blocks external data EEPROM access, CPU unaffected.
// - Clearing protection erases program memory, and data EEPROM during erase.
// - Four user ID words at 8000h-8003h readable and writable.
// - Identifier word at 8006h: part id bits 13-5, revision 4-0.
// - Identifier word is read-only; writes do nothing.
// - External programmers and debuggers can read part id and revision.
// - Program protection at word one bit 7, 0 means enabled.
// - Data protection at word one bit 8, 0 means enabled.
package cfg_pkg;
   localparam logic [15:0] ADDR_USER_ID0 = 16'h8000;
   localparam logic [15:0] ADDR_USER_ID3 = 16'h8003;
   localparam logic [15:0] ADDR_PART_ID = 16'h8006;
   localparam logic [15:0] ADDR_CFG_ONE = 16'h8007;
   localparam logic [15:0] ADDR_CFG_TWO = 16'h8008;
   // Arbitrary neutral identity values
   localparam logic [8:0] PART_ID_VALUE = 9'h0a5;
   localparam logic [4:0] SILICON_REV_VALUE = 5'h01;
   localparam int POS_OSC_LSB = 0;
   localparam int POS_PROG_PROT = 7;
   localparam int POS_DATA_PROT = 8;
   localparam int POS_WRT_LSB = 0;
   localparam int POS_RESERVED = 4;
   localparam int POS_PLL = 8;
   localparam int POS_STACK = 9;
   localparam int POS_BROWNOUT_LEVEL_SELECT = 10;
   localparam int POS_DEBUG = 12;
   localparam int POS_LVP = 13;
   // Word two bits 11, 7..5, 3..2 are unimplemented and read as one
   localparam logic [13:0] CFG_TWO_UNIMPL = 14'h08ec;
   localparam logic [13:0] CFG_RESET = 14'h3fff;
   localparam logic [11:0] WRT_END_SMALL = 12'h1ff;
   localparam logic [11:0] WRT_END_HALF = 12'h7ff;
   localparam logic [11:0] WRT_END_ALL = 12'hfff;
   localparam logic [1:0] LOAD_CYCLES = 2'h2;

   typedef enum logic [2:0] {
      low_power_crystal = 3'b000,
      standard_crystal = 3'b001,
      high_gain_crystal = 3'b010,
      external_rc_oscillator = 3'b011,
      internal_oscillator = 3'b100,
      ext_clock_low_power = 3'b101,
      ext_clock_medium_power = 3'b110,
      ext_clock_high_power = 3'b111
   } osc_mode_type;

   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_FETCH = 2'b01,
      LD_DONE = 2'b10
   } load_state_type;

   // Decoded oscillator pin usage
   typedef struct packed {
      logic ext_logic_clock;
      logic [1:0] ext_power;
      logic internal_osc;
      logic clock_input_pin_is_io;
      logic rc_osc;
      logic crystal;
      logic [1:0] crystal_gain;
   } osc_cfg_type;

   // Decoded system settings
   typedef struct packed {
      logic lvp_allowed;
      logic hv_required;
      logic debug_pins;
      logic bor_low_trip;
      logic stack_reset_en;
      logic pll_on;
      logic prog_protect;
      logic data_protect;
   } sys_cfg_type;
endpackage

// file: rtl/config_word_protection_decode.sv
// Configuration word loader, decoder and external access guard
`timescale 1ns/1ns
module config_word_protection_decode (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Nonvolatile configuration words
   input wire logic [13:0] nv_cfg_one,
   input wire logic [13:0] nv_cfg_two,
   // Programming session status
   input wire logic lvp_entry,
   input wire logic bulk_erase,
   // External programmer register port
   input wire logic [15:0] ext_addr,
   input wire logic [13:0] ext_wdata,
   input wire logic ext_wr,
   input wire logic ext_rd,
   output logic [13:0] ext_rdata,
   // External memory access requests
   input wire logic ext_prog_req,
   input wire logic ext_data_req,
   output logic ext_prog_grant,
   output logic ext_data_grant,
   output logic ext_prog_zero,
   // CPU side access to user ID and memory
   input wire logic [1:0] cpu_uid_addr,
   input wire logic [13:0] cpu_uid_wdata,
   input wire logic cpu_uid_wr,
   output logic [13:0] cpu_uid_rdata,
   input wire logic cpu_prog_req,
   input wire logic cpu_data_req,
   output logic cpu_prog_grant,
   output logic cpu_data_grant,
   // Self-write check
   input wire logic [11:0] self_wr_addr,
   output logic self_wr_blocked,
   // Stack fault
   input wire logic stack_fault,
   output logic stack_reset,
   // Erase commands
   output logic erase_prog_all,
   output logic erase_data_all,
   // Decoded settings
   output cfg_pkg::osc_cfg_type osc_cfg,
   output cfg_pkg::sys_cfg_type sys_cfg,
   output logic [2:0] osc_source_select,
   output logic cfg_valid
);
   import cfg_pkg::*;

   ////////////////////////////////////////////////////////////////
   // Latched configuration and storage
   logic [13:0] cfg_one_r;
   logic [13:0] cfg_two_r;
   logic [13:0] cfg_one_nxt;
   logic [13:0] cfg_two_nxt;
   logic [13:0] user_id_r [4];
   load_state_type load_state_r;
   load_state_type load_state_nxt;
   logic [1:0] load_cnt_r;
   logic [13:0] ext_rdata_r;
   logic [13:0] ext_rdata_nxt;
   logic [13:0] cpu_uid_rdata_r;
   logic erase_prog_r;
   logic erase_data_r;
   // Word images as the cells hold them; settings use the reset copies
   logic [13:0] img_one_r;
   logic [13:0] img_two_r;
   logic [13:0] img_one_nxt;
   logic [13:0] img_two_nxt;

   ////////////////////////////////////////////////////////////////
   // Address decode
   wire logic hit_uid = (ext_addr >= ADDR_USER_ID0) && (ext_addr <= ADDR_USER_ID3);
   wire logic hit_part = (ext_addr == ADDR_PART_ID);
   wire logic hit_one = (ext_addr == ADDR_CFG_ONE);
   wire logic hit_two = (ext_addr == ADDR_CFG_TWO);
   wire logic [1:0] uid_idx = ext_addr[1:0];
   wire logic loaded = (load_state_r == LD_DONE);

   // Field views of latched words
   wire logic [2:0] osc_sel = cfg_one_r[POS_OSC_LSB +: 3];
   wire logic prog_prot_n = cfg_one_r[POS_PROG_PROT];
   wire logic data_prot_n = cfg_one_r[POS_DATA_PROT];
   wire logic [1:0] wrt_field = cfg_two_r[POS_WRT_LSB +: 2];
   wire logic lvp_bit = cfg_two_r[POS_LVP];
   // Readback forces unimplemented positions high
   wire logic [13:0] cfg_two_view = img_two_r | CFG_TWO_UNIMPL;

   // Word two write: keep low-voltage enable set under low-voltage entry
   wire logic [13:0] two_wr_val = lvp_entry ? (ext_wdata | (14'h0001 << POS_LVP))
                                            : ext_wdata;
   wire logic [13:0] one_wr_val = ext_wdata;

   // Protection clear detection
   wire logic prog_unprot = hit_one && ext_wr && !prog_prot_n && one_wr_val[POS_PROG_PROT];
   wire logic data_unprot = hit_one && ext_wr && !data_prot_n && one_wr_val[POS_DATA_PROT]
                            && bulk_erase;

   ////////////////////////////////////////////////////////////////
   // Loader sequence: fetch words for a few cycles after reset
   always_comb begin
      load_state_nxt = load_state_r;
      cfg_one_nxt = cfg_one_r;
      cfg_two_nxt = cfg_two_r;
      case (load_state_r)
         LD_IDLE: begin
            load_state_nxt = LD_FETCH;
         end
         LD_FETCH: begin
            cfg_one_nxt = nv_cfg_one;
            cfg_two_nxt = nv_cfg_two;
            if (load_cnt_r == LOAD_CYCLES) begin
               load_state_nxt = LD_DONE;
            end
         end
         LD_DONE: begin
            // Settings hold; programmed words take effect after next reset
            load_state_nxt = LD_DONE;
         end
         default: begin
            load_state_nxt = LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         load_state_r <= LD_IDLE;
         load_cnt_r <= 2'h0;
         cfg_one_r <= CFG_RESET;
         cfg_two_r <= CFG_RESET;
      end else if (clk_en) begin
         load_state_r <= load_state_nxt;
         cfg_one_r <= cfg_one_nxt;
         cfg_two_r <= cfg_two_nxt;
         if (load_state_r == LD_FETCH) begin
            load_cnt_r <= load_cnt_r + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Word images: loaded with the settings, then follow programmer writes.
   // A write that lands during the load is overwritten by it.
   always_comb begin
      img_one_nxt = img_one_r;
      img_two_nxt = img_two_r;
      if (load_state_r == LD_FETCH) begin
         img_one_nxt = nv_cfg_one;
         img_two_nxt = nv_cfg_two;
      end else if (ext_wr && hit_one) begin
         img_one_nxt = one_wr_val;
      end else if (ext_wr && hit_two) begin
         img_two_nxt = two_wr_val;
      end
   end

   // Images only change what is read back, never the running settings
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         img_one_r <= CFG_RESET;
         img_two_r <= CFG_RESET;
      end else if (clk_en) begin
         img_one_r <= img_one_nxt;
         img_two_r <= img_two_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Oscillator decode
   assign osc_source_select = osc_sel;
   assign osc_cfg.ext_logic_clock = (osc_sel == ext_clock_high_power)
                                  || (osc_sel == ext_clock_medium_power)
                                  || (osc_sel == ext_clock_low_power);
   assign osc_cfg.ext_power = (osc_sel == ext_clock_high_power) ? 2'h2 :
                              (osc_sel == ext_clock_medium_power) ? 2'h1 : 2'h0;
   assign osc_cfg.internal_osc = (osc_sel == internal_oscillator);
   assign osc_cfg.clock_input_pin_is_io = (osc_sel == internal_oscillator);
   assign osc_cfg.rc_osc = (osc_sel == external_rc_oscillator);
   assign osc_cfg.crystal = (osc_sel == high_gain_crystal)
                          || (osc_sel == standard_crystal)
                          || (osc_sel == low_power_crystal);
   assign osc_cfg.crystal_gain = (osc_sel == high_gain_crystal) ? 2'h2 :
                                 (osc_sel == standard_crystal) ? 2'h1 : 2'h0;

   ////////////////////////////////////////////////////////////////
   // System settings decode
   assign sys_cfg.lvp_allowed = lvp_bit;
   assign sys_cfg.hv_required = !lvp_bit;
   assign sys_cfg.debug_pins = !cfg_two_r[POS_DEBUG];
   assign sys_cfg.bor_low_trip = cfg_two_r[POS_BROWNOUT_LEVEL_SELECT];
   assign sys_cfg.stack_reset_en = cfg_two_r[POS_STACK];
   assign sys_cfg.pll_on = cfg_two_r[POS_PLL];
   assign sys_cfg.prog_protect = !prog_prot_n;
   assign sys_cfg.data_protect = !data_prot_n;
   assign cfg_valid = loaded;
   assign stack_reset = stack_fault && cfg_two_r[POS_STACK];

   ////////////////////////////////////////////////////////////////
   // Self-write range check
   wire logic [11:0] wrt_end = (wrt_field == 2'b10) ? WRT_END_SMALL :
                               (wrt_field == 2'b01) ? WRT_END_HALF : WRT_END_ALL;
   assign self_wr_blocked = (wrt_field != 2'b11) && (self_wr_addr <= wrt_end);

   ////////////////////////////////////////////////////////////////
   // Access gating; internal side always passes
   assign ext_prog_grant = ext_prog_req && prog_prot_n;
   assign ext_prog_zero = ext_prog_req && !prog_prot_n;
   assign ext_data_grant = ext_data_req && data_prot_n;
   assign cpu_prog_grant = cpu_prog_req;
   assign cpu_data_grant = cpu_data_req;

   ////////////////////////////////////////////////////////////////
   // External read mux, registered for one-cycle latency
   always_comb begin
      ext_rdata_nxt = 14'h0000;
      if (hit_uid) begin
         ext_rdata_nxt = user_id_r[uid_idx];
      end else if (hit_part) begin
         ext_rdata_nxt = {PART_ID_VALUE, SILICON_REV_VALUE};
      end else if (hit_one) begin
         ext_rdata_nxt = img_one_r;
      end else if (hit_two) begin
         ext_rdata_nxt = cfg_two_view;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_rdata_r <= 14'h0000;
      end else if (clk_en && ext_rd) begin
         ext_rdata_r <= ext_rdata_nxt;
      end
   end
   assign ext_rdata = ext_rdata_r;

   ////////////////////////////////////////////////////////////////
   // User ID store, one entry per generate slot; ID word never written
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_uid
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               user_id_r[gi] <= CFG_RESET;
            end else if (clk_en) begin
               if (ext_wr && hit_uid && (uid_idx == gi)) begin
                  user_id_r[gi] <= ext_wdata;
               end else if (cpu_uid_wr && (cpu_uid_addr == gi)) begin
                  user_id_r[gi] <= cpu_uid_wdata;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_uid_rdata_r <= 14'h0000;
      end else if (clk_en) begin
         cpu_uid_rdata_r <= user_id_r[cpu_uid_addr];
      end
   end
   assign cpu_uid_rdata = cpu_uid_rdata_r;
   // Writes at the identifier address match no store and are dropped

   ////////////////////////////////////////////////////////////////
   // Erase pulses when protection is lifted
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         erase_prog_r <= 1'b0;
         erase_data_r <= 1'b0;
      end else if (clk_en) begin
         erase_prog_r <= prog_unprot;
         erase_data_r <= data_unprot;
      end
   end
   assign erase_prog_all = erase_prog_r;
   assign erase_data_all = erase_data_r;
endmodule

// file: bench/cfg_decode_assertions.sv
// Concurrent checks on the configuration decoder ports
`timescale 1ns/1ns
module cfg_decode_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register port
   input wire logic [15:0] ext_addr,
   input wire logic ext_rd,
   input wire logic [13:0] ext_rdata,
   // Access gates
   input wire logic ext_prog_req,
   input wire logic ext_data_req,
   input wire logic ext_prog_grant,
   input wire logic ext_data_grant,
   input wire logic ext_prog_zero,
   input wire logic cpu_prog_req,
   input wire logic cpu_prog_grant,
   // Stack fault and decoded settings
   input wire logic stack_fault,
   input wire logic stack_reset,
   input cfg_pkg::osc_cfg_type osc_cfg,
   input cfg_pkg::sys_cfg_type sys_cfg,
   input wire logic [2:0] osc_source_select,
   input wire logic cfg_valid
);
   import cfg_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   // Identifier read: strobe taken, then answer one cycle on
   sequence id_read;
      clk_en && ext_rd && ext_addr == ADDR_PART_ID;
   endsequence
   sequence id_answer;
      ext_rdata == {PART_ID_VALUE, SILICON_REV_VALUE};
   endsequence
   a_id_word_read: assert property (id_read |=> id_answer)
      else $error("identifier word read wrong");
   // Oscillator decode, each code family
   a_ext_clock_mode: assert property (osc_source_select >= 3'h5 |->
      osc_cfg.ext_logic_clock && osc_cfg.ext_power == 2'(osc_source_select - 3'h5))
      else $error("external clock decode wrong");
   a_internal_osc: assert property (osc_source_select == 3'h4 |->
      osc_cfg.internal_osc && osc_cfg.clock_input_pin_is_io && !osc_cfg.crystal)
      else $error("internal oscillator decode wrong");
   a_rc_osc_mode: assert property (osc_source_select == 3'h3 |->
      osc_cfg.rc_osc && !osc_cfg.ext_logic_clock) else $error("rc decode wrong");
   a_crystal_gain: assert property (osc_source_select <= 3'h2 |->
      osc_cfg.crystal && osc_cfg.crystal_gain == osc_source_select[1:0])
      else $error("crystal decode wrong");
   // Gates are combinational, so they tie to the settings in the same cycle
   a_stack_reset: assert property (stack_fault |->
      stack_reset == sys_cfg.stack_reset_en) else $error("stack reset wrong");
   a_hv_entry: assert property (sys_cfg.hv_required != sys_cfg.lvp_allowed)
      else $error("programming entry decode wrong");
   a_prog_gate: assert property (ext_prog_req |-> ext_prog_grant !=
      sys_cfg.prog_protect && ext_prog_zero == sys_cfg.prog_protect)
      else $error("program gate wrong");
   a_data_gate: assert property (ext_data_req |->
      ext_data_grant != sys_cfg.data_protect) else $error("data gate wrong");
   a_cpu_pass: assert property (cpu_prog_req |-> cpu_prog_grant)
      else $error("cpu access blocked");
   a_cfg_stable: assert property (cfg_valid && $past(cfg_valid) |->
      $stable(sys_cfg) && $stable(osc_source_select)) else $error("settings moved");
endmodule
bind config_word_protection_decode cfg_decode_checker u_chk (.*);

// file: bench/prog_model.sv
// Programmer model driving the external register port
`timescale 1ns/1ns
module prog_model (
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic [15:0] ext_addr = 16'h0000,
   output logic [13:0] ext_wdata = 14'h0000,
   output logic ext_wr = 1'h0,
   output logic ext_rd = 1'h0,
   input wire logic [13:0] ext_rdata
);
   // Released lines show inverted values so stale data cannot pass
   task automatic wr(input logic [15:0] a, input logic [13:0] d);
      @(posedge clk_sys);
      ext_addr <= a;
      ext_wdata <= d;
      ext_wr <= 1'h1;
      @(posedge clk_sys);
      ext_wr <= 1'h0;
      ext_addr <= ~a;
      ext_wdata <= ~d;
   endtask
   // Read data appear in the cycle after the strobe and hold until the next read
   task automatic rd(input logic [15:0] a, output logic [13:0] d);
      @(posedge clk_sys);
      ext_addr <= a;
      ext_rd <= 1'h1;
      @(posedge clk_sys);
      ext_rd <= 1'h0;
      ext_addr <= ~a;
      #1;
      d = ext_rdata;
   endtask
endmodule

// file: bench/config_word_protection_decode_test.sv
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ns
module config_word_protection_decode_test;
   import cfg_pkg::*;
   logic clk_sys = 1'h0, rst_n = 1'h0, clk_en = 1'h1, lvp_entry = 1'h0, bulk_erase = 1'h0;
   logic [13:0] nv_cfg_one = CFG_RESET, nv_cfg_two = CFG_RESET, cpu_uid_wdata = 14'h0000;
   logic [13:0] ext_wdata, ext_rdata, cpu_uid_rdata, rd_val;
   logic ext_prog_req = 1'h0, ext_data_req = 1'h0, cpu_prog_req = 1'h0, cpu_data_req = 1'h0;
   logic cpu_uid_wr = 1'h0, stack_fault = 1'h0, ext_wr, ext_rd, ext_prog_grant, ext_data_grant;
   logic ext_prog_zero, cpu_prog_grant, cpu_data_grant, self_wr_blocked, stack_reset, cfg_valid;
   logic erase_prog_all, erase_data_all;
   logic [15:0] ext_addr;
   logic [1:0] cpu_uid_addr = 2'h0;
   logic [11:0] self_wr_addr = 12'h000;
   logic [2:0] osc_source_select;
   osc_cfg_type osc_cfg;
   sys_cfg_type sys_cfg;
   int fails = 0;
   int checked = 0;
   config_word_protection_decode DUT (.*);
   prog_model prog (.*);
   always #25 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Settings latch only at reset, so every new setup needs a reload
   task automatic boot(input logic [13:0] one, input logic [13:0] two);
      @(posedge clk_sys);
      nv_cfg_one <= one;
      nv_cfg_two <= two;
      rst_n <= 1'h0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (20) if (cfg_valid !== 1'h1) @(posedge clk_sys);
      #1;
      chk(14'(cfg_valid), 14'h0001);
   endtask
   task automatic probe(input logic [11:0] a, input logic exp);
      @(posedge clk_sys);
      self_wr_addr <= a;
      #1;
      chk(14'(self_wr_blocked), 14'(exp));
   endtask
   // Every oscillator code, self-write code paired to its low bits
   task automatic t_modes();
      logic [11:0] last [4] = '{12'hfff, 12'h7ff, 12'h1ff, 12'h000};
      for (int s = 0; s < 8; s++) begin
         boot({11'h7ff, 3'(s)}, {12'hfff, 2'(s)});
         chk(14'(osc_source_select), 14'(s));
         probe(last[s[1:0]], s[1:0] != 2'h3);
         if (s[1:0] == 2'h1 || s[1:0] == 2'h2) probe(last[s[1:0]] + 12'h001, 1'h0);
      end
   endtask
   // Both protections on, then off; erase fires only on a lifted bit
   task automatic t_protect();
      boot(14'h3e7f, 14'h0612);
      chk(14'(sys_cfg), 14'h007b);
      @(posedge clk_sys);
      ext_prog_req <= 1'h1;
      ext_data_req <= 1'h1;
      cpu_prog_req <= 1'h1;
      cpu_data_req <= 1'h1;
      stack_fault <= 1'h1;
      bulk_erase <= 1'h1;
      #1;
      chk(14'({ext_prog_grant, ext_prog_zero, ext_data_grant}), 14'h0002);
      chk(14'({cpu_prog_grant, cpu_data_grant}), 14'h0003);
      chk(14'(stack_reset), 14'h0001);
      prog.rd(ADDR_CFG_TWO, rd_val);
      chk(rd_val, 14'h0efe);
      prog.wr(ADDR_PART_ID, 14'h0000);
      prog.rd(ADDR_PART_ID, rd_val);
      chk(rd_val, {PART_ID_VALUE, SILICON_REV_VALUE});
      prog.wr(ADDR_CFG_ONE, CFG_RESET);
      #1;
      chk(14'({erase_prog_all, erase_data_all}), 14'h0003);
      @(posedge clk_sys);
      #1;
      chk(14'({erase_prog_all, erase_data_all}), 14'h0000);
      boot(CFG_RESET, CFG_RESET);
      chk(14'(sys_cfg), 14'h009c);
      chk(14'({ext_prog_grant, ext_prog_zero, ext_data_grant}), 14'h0005);
      prog.wr(ADDR_CFG_ONE, CFG_RESET);
      #1;
      chk(14'({erase_prog_all, erase_data_all}), 14'h0000);
   endtask
   // User ID words from both sides, plus an unmapped read
   task automatic t_uid();
      for (int i = 0; i < 4; i++) prog.wr(ADDR_USER_ID0 + 16'(i), 14'h1550 + 14'(i));
      @(posedge clk_sys);
      cpu_uid_addr <= 2'h3;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(cpu_uid_rdata, 14'h1553);
      @(posedge clk_sys);
      cpu_uid_addr <= 2'h1;
      cpu_uid_wdata <= 14'h2aaa;
      cpu_uid_wr <= 1'h1;
      @(posedge clk_sys);
      // Strobe held while the enable is low: this write must be frozen out
      clk_en <= 1'h0;
      cpu_uid_addr <= 2'h2;
      @(posedge clk_sys);
      clk_en <= 1'h1;
      cpu_uid_wr <= 1'h0;
      prog.rd(16'h8001, rd_val);
      chk(rd_val, 14'h2aaa);
      prog.rd(16'h8002, rd_val);
      chk(rd_val, 14'h1552);
      prog.rd(16'h8004, rd_val);
      chk(rd_val, 14'h0000);
   endtask
   // Low-voltage session keeps the enable bit; high-voltage one may clear it
   task automatic t_lvp();
      @(posedge clk_sys);
      lvp_entry <= 1'h1;
      prog.wr(ADDR_CFG_TWO, 14'h0000);
      prog.rd(ADDR_CFG_TWO, rd_val);
      chk(rd_val, CFG_TWO_UNIMPL | 14'h2000);
      @(posedge clk_sys);
      lvp_entry <= 1'h0;
      prog.wr(ADDR_CFG_TWO, 14'h0000);
      prog.rd(ADDR_CFG_TWO, rd_val);
      chk(rd_val, CFG_TWO_UNIMPL);
      chk(14'(sys_cfg.lvp_allowed), 14'h0001);
   endtask
   initial begin
      t_modes();
      t_protect();
      t_uid();
      t_lvp();
      give_verdict();
   end
   // Whole run is a few hundred cycles; this margin only catches a hang
   initial begin
      #2000000;
      fails++;
      give_verdict();
   end
endmodule
